// ===== common/host_cmd_map.svh
// Offsets, field positions, codes and timing counts of the host command parser
`ifndef HOST_CMD_MAP_SVH
`define HOST_CMD_MAP_SVH
`define CLK_HZ 20000000
`define CTS_TIMEOUT_S 5
`define OFS_CTRL 4'h0
`define OFS_STATUS 4'h4
`define OFS_TXDATA 4'h8
`define CTRL_CKSUM_BIT 8
`define CTRL_MSTAB_BIT 9
`define STAT_TXBUSY_BIT 16
`define STAT_TXPEND_BIT 17
`define STAT_ABORT_BIT 18
`define STAT_MSTAB_BIT 19
`define ADDR_RST 7'h41
`define BAUD_DIV_RST 16'h0823
`define CHR_SOH 8'h01
`define CHR_EOT 8'h04
`define CHR_CR 8'h0d
`define ADDR_MIN 8'h41
`define ADDR_MAX 8'h53
`define TANK_MIN 8'h30
`define TANK_MAX 8'h38
`define DIGIT_MIN 8'h30
`define DIGIT_MAX 8'h39
`define FRAME_BITS 4'h9
`endif

// ===== common/host_cmd_pkg.sv
// Types shared by the host command parser
package host_cmd_pkg;
   typedef enum logic [2:0] {P_IDLE, P_ADDR, P_TANK, P_HI, P_LO, P_TERM} parse_state_t;
endpackage

// ===== rtl/host_serial_command_parser.sv
// Host port receiver, command decoder, gated transmitter and Avalon-MM registers
//
// Design decisions made here: the Avalon-MM register port and the address map.
`include "host_cmd_map.svh"
module host_serial_command_parser #(
   parameter int unsigned CTS_TIMEOUT_CYCLES = `CTS_TIMEOUT_S * `CLK_HZ
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rxd,
   output logic txd,
   input wire logic cts,
   output logic cmd_valid,
   output logic [3:0] cmd_tank,
   output logic [6:0] cmd_code,
   output logic cmd_all_tanks
);
   logic rx_m_r, rx_s_r, cts_m_r, cts_s_r;
   logic [6:0] own_addr_r;
   logic cksum_en_r, mass_stab_r, abort_r;
   logic [15:0] baud_div_r;
   logic ack_r;
   logic rx_act_r, tx_busy_r, tx_pend_r;
   logic [15:0] rx_cnt_r, tx_cnt_r;
   logic [3:0] rx_bit_r, tx_bit_r;
   logic [7:0] rx_sh_r, rx_byte_r, tx_data_r;
   logic [9:0] tx_sh_r;
   logic byte_vld_r;
   logic [31:0] cts_wait_r;
   host_cmd_pkg::parse_state_t ps_r;
   logic [3:0] tank_r, hi_r, lo_dig;
   logic [6:0] code_full, code_r;
   logic wr_ctrl, wr_stat, wr_tx, tx_start, timeout_hit, commit;

   function automatic logic code_ok(input logic [6:0] c);
      code_ok = (c <= 7'd14) || (c == 7'd20) || (c == 7'd21) || (c >= 7'd30 && c <= 7'd32) ||
         (c == 7'd60) || (c == 7'd61);
   endfunction

   function automatic logic is_digit(input logic [7:0] b);
      is_digit = (b >= `DIGIT_MIN) && (b <= `DIGIT_MAX);
   endfunction

   // Pin synchronisers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_m_r <= 1'b1;
         rx_s_r <= 1'b1;
         cts_m_r <= 1'b0;
         cts_s_r <= 1'b0;
      end else begin
         rx_m_r <= rxd;
         rx_s_r <= rx_m_r;
         cts_m_r <= cts;
         cts_s_r <= cts_m_r;
      end
   end

   // Avalon slave: one wait state, then answer
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wr_ctrl = avs_write && ack_r && (avs_address == `OFS_CTRL);
   assign wr_stat = avs_write && ack_r && (avs_address == `OFS_STATUS);
   assign wr_tx = avs_write && ack_r && (avs_address == `OFS_TXDATA) && avs_byteenable[0];

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_r <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
         avs_readdata <= 32'h0000_0000;
         if (avs_read && !ack_r) begin
            unique case (avs_address)
               `OFS_CTRL: avs_readdata <= {baud_div_r, 6'h00, mass_stab_r, cksum_en_r,
                  1'b0, own_addr_r};
               `OFS_STATUS: avs_readdata <= {12'h000, mass_stab_r, abort_r, tx_pend_r,
                  tx_busy_r, 5'h00, cmd_code, cmd_tank};
               `OFS_TXDATA: avs_readdata <= {24'h000000, tx_data_r};
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Settings
   always_ff @(posedge clk) begin
      if (!resetn) begin
         own_addr_r <= `ADDR_RST;
         cksum_en_r <= 1'b0;
         baud_div_r <= `BAUD_DIV_RST;
      end else if (wr_ctrl) begin
         if (avs_byteenable[0] && avs_writedata[7:0] >= `ADDR_MIN &&
            avs_writedata[7:0] <= `ADDR_MAX) begin
            own_addr_r <= avs_writedata[6:0];
         end
         if (avs_byteenable[1]) begin
            cksum_en_r <= avs_writedata[`CTRL_CKSUM_BIT];
         end
         if (avs_byteenable[2] && avs_byteenable[3] && avs_writedata[31:16] != 16'h0000) begin
            baud_div_r <= avs_writedata[31:16];
         end
      end
   end

   // Host commands take priority over software
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mass_stab_r <= 1'b0;
      end else if (commit && code_r == 7'd20) begin
         mass_stab_r <= 1'b1;
      end else if (commit && code_r == 7'd21) begin
         mass_stab_r <= 1'b0;
      end else if (wr_ctrl && avs_byteenable[1]) begin
         mass_stab_r <= avs_writedata[`CTRL_MSTAB_BIT];
      end
   end

   // Receiver; ignored while transmitting so nothing is echoed
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_act_r <= 1'b0;
         rx_cnt_r <= 16'h0000;
         rx_bit_r <= 4'h0;
         rx_sh_r <= 8'h00;
         rx_byte_r <= 8'h00;
         byte_vld_r <= 1'b0;
      end else begin
         byte_vld_r <= 1'b0;
         if (!rx_act_r) begin
            // A start bit in the cycle a character launches is dropped, not raced
            if (!rx_s_r && !tx_busy_r && !tx_start) begin
               rx_act_r <= 1'b1;
               rx_cnt_r <= {1'b0, baud_div_r[15:1]};
               rx_bit_r <= 4'h0;
            end
         end else if (rx_cnt_r != 16'h0000) begin
            rx_cnt_r <= rx_cnt_r - 16'h0001;
         end else begin
            rx_cnt_r <= baud_div_r - 16'h0001;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0) begin
               rx_act_r <= !rx_s_r;
            end else if (rx_bit_r == `FRAME_BITS) begin
               rx_act_r <= 1'b0;
               // Bad parity or stop drops the character
               if (rx_s_r && (cksum_en_r || !(^rx_sh_r))) begin
                  byte_vld_r <= 1'b1;
                  rx_byte_r <= cksum_en_r ? rx_sh_r : {1'b0, rx_sh_r[6:0]};
               end
            end else begin
               rx_sh_r <= {rx_s_r, rx_sh_r[7:1]};
            end
         end
      end
   end

   // Command parser
   assign lo_dig = rx_byte_r[3:0];
   assign code_full = (7'(hi_r) * 7'd10) + 7'(lo_dig);
   assign commit = byte_vld_r && ps_r == host_cmd_pkg::P_TERM &&
      (rx_byte_r == `CHR_EOT || rx_byte_r == `CHR_CR);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ps_r <= host_cmd_pkg::P_IDLE;
         tank_r <= 4'h0;
         hi_r <= 4'h0;
         code_r <= 7'h00;
      end else if (byte_vld_r) begin
         ps_r <= host_cmd_pkg::P_IDLE;
         if (rx_byte_r == `CHR_SOH) begin
            ps_r <= host_cmd_pkg::P_ADDR;
         end else begin
            unique case (ps_r)
               host_cmd_pkg::P_IDLE: ps_r <= host_cmd_pkg::P_IDLE;
               host_cmd_pkg::P_ADDR: begin
                  if (rx_byte_r == {1'b0, own_addr_r}) begin
                     ps_r <= host_cmd_pkg::P_TANK;
                  end
               end
               host_cmd_pkg::P_TANK: begin
                  if (rx_byte_r >= `TANK_MIN && rx_byte_r <= `TANK_MAX) begin
                     tank_r <= rx_byte_r[3:0];
                     ps_r <= host_cmd_pkg::P_HI;
                  end
               end
               host_cmd_pkg::P_HI: begin
                  if (is_digit(rx_byte_r)) begin
                     hi_r <= rx_byte_r[3:0];
                     ps_r <= host_cmd_pkg::P_LO;
                  end
               end
               host_cmd_pkg::P_LO: begin
                  if (is_digit(rx_byte_r) && code_ok(code_full)) begin
                     // Kept, as the terminator byte replaces the low digit
                     code_r <= code_full;
                     ps_r <= host_cmd_pkg::P_TERM;
                  end
               end
               host_cmd_pkg::P_TERM: ps_r <= host_cmd_pkg::P_IDLE;
            endcase
         end
      end
   end

   // Request to response logic
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmd_valid <= 1'b0;
         cmd_tank <= 4'h0;
         cmd_code <= 7'h00;
         cmd_all_tanks <= 1'b0;
      end else begin
         cmd_valid <= commit;
         if (commit) begin
            cmd_tank <= tank_r;
            cmd_code <= code_r;
            cmd_all_tanks <= (tank_r == 4'h0);
         end
      end
   end

   // Transmitter, gated by clear-to-send between characters
   assign tx_start = tx_pend_r && cts_s_r && !tx_busy_r && !rx_act_r;
   assign timeout_hit = tx_pend_r && !cts_s_r && !tx_busy_r &&
      cts_wait_r == CTS_TIMEOUT_CYCLES - 1;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_pend_r <= 1'b0;
         tx_data_r <= 8'h00;
      end else if (tx_start || timeout_hit) begin
         tx_pend_r <= 1'b0;
      end else if (wr_tx && !tx_pend_r) begin
         tx_pend_r <= 1'b1;
         tx_data_r <= avs_writedata[7:0];
      end
   end

   // Wait counter; abort flag set wins over write-one clear
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cts_wait_r <= 32'h0000_0000;
         abort_r <= 1'b0;
      end else begin
         if (!tx_pend_r || cts_s_r || timeout_hit) begin
            cts_wait_r <= 32'h0000_0000;
         end else begin
            cts_wait_r <= cts_wait_r + 32'h0000_0001;
         end
         if (timeout_hit) begin
            abort_r <= 1'b1;
         end else if (wr_stat && avs_byteenable[2] && avs_writedata[`STAT_ABORT_BIT]) begin
            abort_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_busy_r <= 1'b0;
         tx_cnt_r <= 16'h0000;
         tx_bit_r <= 4'h0;
         tx_sh_r <= 10'h3ff;
         txd <= 1'b1;
      end else if (tx_start) begin
         tx_busy_r <= 1'b1;
         tx_cnt_r <= baud_div_r - 16'h0001;
         tx_bit_r <= 4'h0;
         txd <= 1'b0;
         tx_sh_r <= cksum_en_r ? {1'b1, tx_data_r, 1'b0} :
            {1'b1, ^tx_data_r[6:0], tx_data_r[6:0], 1'b0};
      end else if (tx_busy_r) begin
         if (tx_cnt_r != 16'h0000) begin
            tx_cnt_r <= tx_cnt_r - 16'h0001;
         end else begin
            tx_cnt_r <= baud_div_r - 16'h0001;
            tx_bit_r <= tx_bit_r + 4'h1;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            txd <= tx_sh_r[1];
            if (tx_bit_r == `FRAME_BITS) begin
               tx_busy_r <= 1'b0;
               txd <= 1'b1;
            end
         end
      end
   end

   // Checks
   tx_cts_gate_a: assert property (@(posedge clk) disable iff (!resetn)
      !cts_s_r && !tx_busy_r |=> !tx_busy_r) else $error("transmit started without cts");
   cts_abort_a: assert property (@(posedge clk) disable iff (!resetn)
      timeout_hit |=> !tx_pend_r && abort_r && !tx_busy_r) else $error("cts abort missed");
   half_duplex_a: assert property (@(posedge clk) disable iff (!resetn)
      tx_busy_r |-> !$rose(rx_act_r)) else $error("receive began during transmit");
   parity_frame_a: assert property (@(posedge clk) disable iff (!resetn)
      tx_start && !cksum_en_r |=> !txd && !(^tx_sh_r[8:1]) && tx_sh_r[9])
      else $error("bad even parity frame");
   cksum_frame_a: assert property (@(posedge clk) disable iff (!resetn)
      tx_start && cksum_en_r |=> tx_sh_r[8:1] == $past(tx_data_r) && tx_sh_r[9])
      else $error("bad eight bit frame");
   cmd_once_a: assert property (@(posedge clk) disable iff (!resetn)
      cmd_valid |=> !cmd_valid) else $error("request longer than one cycle");
   cmd_term_a: assert property (@(posedge clk) disable iff (!resetn)
      cmd_valid |-> $past(rx_byte_r) == `CHR_EOT || $past(rx_byte_r) == `CHR_CR)
      else $error("request without terminator");
   cmd_fields_a: assert property (@(posedge clk) disable iff (!resetn)
      cmd_valid |-> cmd_tank <= 4'h8 && code_ok(cmd_code) && cmd_all_tanks == (cmd_tank == 4'h0))
      else $error("request fields invalid");
   soh_restart_a: assert property (@(posedge clk) disable iff (!resetn)
      byte_vld_r && rx_byte_r == `CHR_SOH |=> ps_r == host_cmd_pkg::P_ADDR)
      else $error("start of header did not restart");
   addr_match_a: assert property (@(posedge clk) disable iff (!resetn)
      byte_vld_r && ps_r == host_cmd_pkg::P_ADDR && rx_byte_r != {1'b0, own_addr_r}
      |=> ps_r != host_cmd_pkg::P_TANK) else $error("foreign address accepted");
   mass_cmd_a: assert property (@(posedge clk) disable iff (!resetn)
      cmd_valid && cmd_code == 7'd20 |-> mass_stab_r) else $error("mass mode not set");
   cmd_cr_c: cover property (@(posedge clk) cmd_valid && $past(rx_byte_r) == `CHR_CR);
   cmd_all_c: cover property (@(posedge clk) cmd_valid && cmd_all_tanks);
   cts_abort_c: cover property (@(posedge clk) timeout_hit);
   tx_frame_c: cover property (@(posedge clk) tx_start ##1 tx_busy_r [*3]);
endmodule // host_serial_command_parser

// ===== verification/host_serial_command_parser_bench.sv
// Self-checking bench for the host command parser
module host_serial_command_parser_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, rxd, txd, cts, cmd_valid, cmd_all_tanks, got_all;
   logic [3:0] cmd_tank, got_tank, t;
   logic [6:0] cmd_code, got_code, c;
   logic [6:0] extra [7] = '{7'h14, 7'h15, 7'h1e, 7'h1f, 7'h20, 7'h3c, 7'h3d};
   logic [39:0] bad [6] = '{40'h4131303104, 40'h4239303104, 40'h4231313504,
      40'h4231323204, 40'h42313a3104, 40'h4231303158};
   logic ck = 1'b0;
   logic [31:0] rd;
   logic [8:0] frame;
   int n_mismatch = 0;
   int total_checks = 0;
   int n_cmd = 0;
   int n_echo = 0;
   int n_low;

   always #25 clk = ~clk;

   host_serial_command_parser #(.CTS_TIMEOUT_CYCLES(200)) dut (.clk(clk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .txd(txd),
      .cts(cts), .cmd_valid(cmd_valid), .cmd_tank(cmd_tank), .cmd_code(cmd_code),
      .cmd_all_tanks(cmd_all_tanks));
   host_terminal_model host (.clk(clk), .rxd(rxd), .txd(txd), .cts(cts));

   always @(posedge clk) begin
      if (cmd_valid === 1'b1) begin
         n_cmd++;
         got_tank = cmd_tank;
         got_code = cmd_code;
         got_all = cmd_all_tanks;
      end
      if (host.busy && txd !== 1'b1) n_echo++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      check(q, exp);
   endtask
   task automatic send_cmd(input logic [39:0] f);
      host.send_char(8'h01, ck);
      for (int i = 4; i >= 0; i--) host.send_char(f[i*8+:8], ck);
      repeat (host.div * 3) @(posedge clk);
   endtask
   task automatic cmd_ok(input logic [39:0] f, input logic [3:0] et, input logic [6:0] ec);
      int n0;
      n0 = n_cmd;
      send_cmd(f);
      check(32'(n_cmd - n0), 32'h1);
      check(32'(got_tank), 32'(et));
      check(32'(got_code), 32'(ec));
      check(32'(got_all), 32'(et == 4'h0));
   endtask
   task automatic tx_quiet();
      n_low = 0;
      repeat (100) begin
         @(posedge clk);
         if (txd !== 1'b1) n_low++;
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Commands take about a thousand cycles each; generous margin
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(4'h0, 32'h08230041);
      rdc(4'h4, 32'h00000000);
      rdc(4'hc, 32'h00000000);
      wr(4'h0, 32'h00100054, 4'hf);
      rdc(4'h0, 32'h00100041);
      wr(4'h0, 32'h00100042, 4'hf);
      rdc(4'h0, 32'h00100042);
      $display("test registers done");
      cmd_ok(40'h4231303304, 4'h1, 7'h03);
      rdc(4'h4, 32'h00000031);
      cmd_ok(40'h423031340d, 4'h0, 7'h0e);
      host.send_char(8'h01, ck);
      host.send_char(8'h42, ck);
      cmd_ok(40'h423231310d, 4'h2, 7'h0b);
      $display("test framing done");
      for (int i = 0; i < 22; i++) begin
         t = 4'(i % 9);
         c = (i < 15) ? 7'(i) : extra[i - 15];
         cmd_ok({8'h42, 8'h30 + 8'(t), 8'h30 + 8'(c / 10), 8'h30 + 8'(c % 10), 8'h04}, t, c);
         if (c == 7'h14) rdc(4'h0, 32'h00100242);
         if (c == 7'h15) rdc(4'h0, 32'h00100042);
      end
      $display("test codes done");
      for (int i = 0; i < 6; i++) begin
         n_low = n_cmd;
         send_cmd(bad[i]);
         check(32'(n_cmd - n_low), 32'h0);
      end
      check(32'(n_echo), 32'h0);
      $display("test discard done");
      host.hold(1'b0);
      repeat (4) @(posedge clk);
      wr(4'h8, 32'h00000043, 4'h1);
      tx_quiet();
      check(32'(n_low), 32'h0);
      host.hold(1'b1);
      host.get_char(frame);
      check(32'(frame), 32'h1c3);
      host.hold(1'b0);
      repeat (4) @(posedge clk);
      wr(4'h8, 32'h00000041, 4'h1);
      repeat (300) @(posedge clk);
      rdc(4'h4, 32'h000403d3);
      host.hold(1'b1);
      tx_quiet();
      check(32'(n_low), 32'h0);
      wr(4'h4, 32'h00040000, 4'h4);
      rdc(4'h4, 32'h000003d3);
      $display("test transmit done");
      wr(4'h0, 32'h00100142, 4'hf);
      ck = 1'b1;
      cmd_ok(40'h4238313304, 4'h8, 7'h0d);
      wr(4'h8, 32'h00000093, 4'h1);
      host.get_char(frame);
      check(32'(frame), 32'h193);
      $display("test checksum mode done");
      close_out();
   end
endmodule // host_serial_command_parser_bench

// ===== verification/host_terminal_model.sv
// Behavioural host terminal on the far side of the serial host port
module host_terminal_model (
   input wire logic clk,
   output logic rxd,
   input wire logic txd,
   output logic cts
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bit time in clocks; must mirror the programmed divisor
   int div = 16;
   // Marks our own sending so the bench can watch for echo
   logic busy = 1'b0;
   initial begin
      rxd = 1'b1;
      // Low models a full logging buffer; bench drives it
      cts = 1'b1;
   end
   // One host, one monitor address per command
   task automatic send_char(input logic [7:0] c, input logic ck);
      logic [9:0] f;
      f = ck ? {1'b1, c, 1'b0} : {1'b1, ^c[6:0], c[6:0], 1'b0};
      busy <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (div) @(posedge clk);
      end
      busy <= 1'b0;
   endtask
   // Returns eight payload bits and the stop bit, sampled mid-bit
   task automatic get_char(output logic [8:0] q);
      q = 9'h000;
      for (int i = 0; i < 2000 && txd !== 1'b0; i++) @(posedge clk);
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (div) @(posedge clk);
         q[i] = txd;
      end
   endtask
   // Clear-to-send level, changed only at a rising edge
   task automatic hold(input logic v);
      cts <= v;
   endtask
endmodule // host_terminal_model
